// *** hw/sensor_subsys_irq_flags.sv ***
// Interrupt flag and enable registers of the sensor subsystem.
// Assumes a single pclk domain, APB master, and event sources
// that are synchronous to pclk.
//
// Contract
// - Address NACK sets flag six or seven
// - Sleeping memory access sets bank flag
// - Engine breakpoint sets flag thirteen
// - Packet FIFO overflow sets flag fifteen
// - Sequencer breakpoints set flags sixteen, seventeen
// - Serial master request sets flag eighteen
// - AHB error response sets flag twenty-two
// - Enables six, seven gate NACK flags
// - Enable register at 0x10c resets masked
// - Multiple FIFO push sets flag zero
// - Overrun flags cleared only by reset
`timescale 1ns/100ps
`default_nettype none

`include "irq_flags_params.svh"

module sensor_subsys_irq_flags
  import irq_flags_pkg::*;
#(
  parameter int unsigned ADDR_W = `IRQ_ADDR_W,
  parameter int unsigned DATA_W = 32
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output var  logic [DATA_W-1:0] prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire irq_src_t          src,
  output var  logic              irq
);

  // ----------------------------------------------------------------
  // Local functions
  // ----------------------------------------------------------------

  // Register selected by a byte address, used by read and write
  typedef enum logic [1:0] {
    SEL_NONE   = 2'b00,
    SEL_FLAG   = 2'b01,
    SEL_ENABLE = 2'b10
  } reg_sel_t;

  function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a == ADDR_W'(`IRQ_FLAG_STATUS_OFS)) begin
      s = SEL_FLAG;
    end else if (a == ADDR_W'(`IRQ_ENABLE_MASK_OFS)) begin
      s = SEL_ENABLE;
    end
    return s;
  endfunction

  // True when more than one select bit is high
  function automatic logic more_than_one(input logic [`PUSH_SEL_W-1:0] v);
    logic [`PUSH_SEL_W-1:0] low_cleared;
    low_cleared = v & (v - `PUSH_SEL_W'(1));
    return |low_cleared;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  apb_state_t        apb_state_r;
  apb_state_t        apb_state_nxt;
  logic [DATA_W-1:0] enable_r;
  logic [DATA_W-1:0] flags;
  logic [DATA_W-1:0] flag_set;
  logic [DATA_W-1:0] flag_clr;
  logic [DATA_W-1:0] rd_value;
  logic              access_done;
  logic              wr_commit;
  reg_sel_t          cur_sel;
  logic              ahb_err_evt;
  logic              pkt_ovf_evt;
  logic              multi_push_evt;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------

  assign multi_push_evt = src.engine_push && more_than_one(src.engine_push_sel);

  assign pkt_ovf_evt = src.pkt_fifo_push && src.pkt_fifo_full;

  // error response seen
  // Either cycle of the two-cycle error answer sets the flag
  assign ahb_err_evt = src.ahbm_hresp;

  // Gather events into flag positions; unused bits never set
  always_comb begin
    flag_set = '0;
    flag_set[`MULTI_PUSH_BIT]     = multi_push_evt;
    flag_set[`ENGINE_OVERRUN_BIT] = src.engine_overrun;
    flag_set[`SEQ_B_OVERRUN_BIT]  = src.seq_b_overrun;
    flag_set[`SEQ_A_OVERRUN_BIT]  = src.seq_a_overrun;
    flag_set[`IIC_M1_NACK_BIT]    = src.iic_m1_nack;
    flag_set[`IIC_M0_NACK_BIT]    = src.iic_m0_nack;
    flag_set[`CODE_MEM_LG_BIT]    = src.mem_sleep_access[0];
    flag_set[`DATA_MEM_A_BIT]     = src.mem_sleep_access[1];
    flag_set[`DATA_MEM_B_BIT]     = src.mem_sleep_access[2];
    flag_set[`SEQ_MEM_A_BIT]      = src.mem_sleep_access[3];
    flag_set[`SEQ_MEM_B_BIT]      = src.mem_sleep_access[4];
    flag_set[`CODE_MEM_SM_BIT]    = src.mem_sleep_access[5];
    flag_set[`DATA_MEM_C_BIT]     = src.mem_sleep_access[6];
    flag_set[`DATA_MEM_D_BIT]     = src.mem_sleep_access[7];
    flag_set[`ENGINE_BP_BIT]      = src.engine_bp;
    flag_set[`PKT_FIFO_OVF_BIT]   = pkt_ovf_evt;
    flag_set[`SEQ_A_BP_BIT]       = src.seq_a_bp;
    flag_set[`SEQ_B_BP_BIT]       = src.seq_b_bp;
    flag_set[`SERIAL_REQ_BIT]     = src.serial_req;
    flag_set[`AHBM_ERR_BIT]       = ahb_err_evt;
  end

  // ----------------------------------------------------------------
  // APB slave sequencing
  // ----------------------------------------------------------------

  // Data comes from a flop, so the access phase takes two cycles:
  // one to register the answer, one with pready high.
  always_comb begin
    apb_state_nxt = apb_state_r;
    case (apb_state_r)
      APB_IDLE: begin
        if (psel && !penable) begin
          apb_state_nxt = APB_ACCESS;
        end
      end
      APB_ACCESS: begin
        if (psel && penable) begin
          apb_state_nxt = APB_RESP;
        end
      end
      APB_RESP: begin
        apb_state_nxt = APB_IDLE;
      end
      default: begin
        apb_state_nxt = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state_r <= APB_IDLE;
    end else begin
      apb_state_r <= apb_state_nxt;
    end
  end

  // Transfer completes at the edge where pready is seen high
  assign access_done = (apb_state_r == APB_RESP) && psel && penable;
  assign wr_commit   = access_done && pwrite;
  assign cur_sel     = decode_addr(paddr);

  // ----------------------------------------------------------------
  // Response flops
  // ----------------------------------------------------------------

  // Ready rises for one cycle; error rises with it only for an unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (apb_state_nxt == APB_RESP) begin
      pready  <= 1'b1;
      pslverr <= (cur_sel == SEL_NONE);
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Read value; unmapped addresses and writes return zero
  always_comb begin
    rd_value = `IRQ_RDATA_RST;
    if (!pwrite) begin
      if (cur_sel == SEL_FLAG) begin
        rd_value = flags & `IRQ_FLAG_IMPL_MASK;
      end else if (cur_sel == SEL_ENABLE) begin
        rd_value = enable_r;
      end
    end
  end

  // Sampled one cycle ahead of pready; a flag set in that cycle
  // shows on the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `IRQ_RDATA_RST;
    end else if (apb_state_nxt == APB_RESP) begin
      prdata <= rd_value;
    end else begin
      prdata <= `IRQ_RDATA_RST;
    end
  end

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= `IRQ_ENABLE_RST;
    end else if (wr_commit && cur_sel == SEL_ENABLE) begin
      enable_r <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Flag register
  // ----------------------------------------------------------------

  assign flag_clr = (wr_commit && cur_sel == SEL_FLAG) ? pwdata : '0;

  irq_flag_cell #(
    .WIDTH    (DATA_W),
    .CLR_MASK (`IRQ_FLAG_CLR_MASK),
    .RST_VAL  (`IRQ_FLAG_RST)
  ) u_flags (
    .clk   (pclk),
    .rst_n (presetn),
    .set   (flag_set),
    .clr   (flag_clr),
    .flags (flags)
  );

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------

  // any enabled flag
  // Registered, so it follows the flags by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & enable_r & `IRQ_FLAG_IMPL_MASK);
    end
  end

endmodule

`default_nettype wire

// *** hw/irq_flags_params.svh ***
// Constants for the sensor subsystem interrupt flag block.
// Assumes a 32-bit APB slave with byte addresses and aligned words.
`ifndef IRQ_FLAGS_PARAMS_SVH
`define IRQ_FLAGS_PARAMS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define IRQ_ADDR_W          12
`define IRQ_FLAG_STATUS_OFS 12'h108
`define IRQ_ENABLE_MASK_OFS 12'h10c

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IRQ_FLAG_RST        32'h0000_0000
`define IRQ_ENABLE_RST      32'h0000_0000
`define IRQ_RDATA_RST       32'h0000_0000

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define MULTI_PUSH_BIT      0
`define ENGINE_OVERRUN_BIT  1
`define SEQ_B_OVERRUN_BIT   4
`define SEQ_A_OVERRUN_BIT   5
`define IIC_M1_NACK_BIT     6
`define IIC_M0_NACK_BIT     7
`define CODE_MEM_LG_BIT     8
`define DATA_MEM_A_BIT      9
`define DATA_MEM_B_BIT      10
`define SEQ_MEM_A_BIT       11
`define SEQ_MEM_B_BIT       12
`define ENGINE_BP_BIT       13
`define PKT_FIFO_OVF_BIT    15
`define SEQ_A_BP_BIT        16
`define SEQ_B_BP_BIT        17
`define SERIAL_REQ_BIT      18
`define CODE_MEM_SM_BIT     19
`define DATA_MEM_C_BIT      20
`define DATA_MEM_D_BIT      21
`define AHBM_ERR_BIT        22

// ----------------------------------------------------------------
// Field masks
// ----------------------------------------------------------------
// Bits that hold a flag; the rest read as zero
`define IRQ_FLAG_IMPL_MASK  32'h007f_bff3
// Bits that a write of one may clear; overruns need a device reset
`define IRQ_FLAG_CLR_MASK   32'h007f_bfc1

// ----------------------------------------------------------------
// Source widths
// ----------------------------------------------------------------
`define PUSH_SEL_W          4
`define MEM_BANKS           8

`endif

// *** hw/irq_flags_pkg.sv ***
// Types shared by the interrupt flag block and its bench.
// Assumes irq_flags_params.svh is on the include path.
`include "irq_flags_params.svh"

package irq_flags_pkg;

  // ----------------------------------------------------------------
  // Event sources, one cycle pulses or levels in the pclk domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                    engine_push;         // Engine push strobe
    logic [`PUSH_SEL_W-1:0]  engine_push_sel;     // FIFO select, one hot
    logic                    engine_overrun;      // Engine missed sample period
    logic                    seq_a_overrun;       // Sequencer A missed period
    logic                    seq_b_overrun;       // Sequencer B missed period
    logic                    iic_m1_nack;         // Address NACK, master one
    logic                    iic_m0_nack;         // Address NACK, master zero
    logic [`MEM_BANKS-1:0]   mem_sleep_access;    // Access to a sleeping bank
    logic                    engine_bp;           // Engine breakpoint match
    logic                    pkt_fifo_push;       // Engine push into packet FIFO
    logic                    pkt_fifo_full;       // Packet FIFO is full
    logic                    seq_a_bp;            // Sequencer A breakpoint
    logic                    seq_b_bp;            // Sequencer B breakpoint
    logic                    serial_req;          // Serial master request
    logic                    ahbm_hresp;          // AHB master response
    logic                    ahbm_hready;         // AHB master ready
  } irq_src_t;

  // ----------------------------------------------------------------
  // APB slave states, one hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    APB_IDLE   = 3'b001,
    APB_ACCESS = 3'b010,
    APB_RESP   = 3'b100
  } apb_state_t;

endpackage

// *** hw/irq_flag_cell.sv ***
// Bank of sticky flag bits with write-one-to-clear.
// Assumes set and clear are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module irq_flag_cell #(
  parameter int unsigned      WIDTH    = 32,
  parameter logic [WIDTH-1:0] CLR_MASK = '1,
  parameter logic [WIDTH-1:0] RST_VAL  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output var  logic [WIDTH-1:0] flags
);

  // ----------------------------------------------------------------
  // One sticky bit per position
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gen_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flags[g] <= RST_VAL[g];
        end else if (set[g]) begin
          flags[g] <= 1'b1;
        end else if (clr[g] && CLR_MASK[g]) begin
          flags[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// *** tb/irq_flags_checker_props.sv ***
// Checker for the interrupt flag block, bound to its top module.
// Assumes one pclk domain and the package compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "irq_flags_params.svh"
module irq_flags_checker
  import irq_flags_pkg::*;
#(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned DATA_W = 32
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire irq_src_t          src,
  input wire logic              irq
);
  logic [DATA_W-1:0] en_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow enables, so the irq checks need no view of the body
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= '0;
    end else if (psel && penable && pready && pwrite && paddr == `IRQ_ENABLE_MASK_OFS) begin
      en_r <= pwdata;
    end
  end
  // ----------------------------------------------------------------
  // Sequences and assertions
  // ----------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_nack_m0;
    src.iic_m0_nack ##1 en_r[`IIC_M0_NACK_BIT];
  endsequence
  sequence s_ahb_err;
    src.ahbm_hresp ##1 en_r[`AHBM_ERR_BIT];
  endsequence
  sequence s_multi_push;
    src.engine_push && $countones(src.engine_push_sel) > 1 ##1 en_r[`MULTI_PUSH_BIT];
  endsequence
  a_ready_timing: assert property (s_setup |-> ##2 (pready && penable))
    else $error("transfer not answered in time");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error outside a transfer end");
  a_rdata_idle: assert property (!pready |-> prdata == '0)
    else $error("read data outside answer");
  a_err_unmapped: assert property (
    pready |-> pslverr == (paddr != `IRQ_FLAG_STATUS_OFS && paddr != `IRQ_ENABLE_MASK_OFS))
    else $error("error flag wrong for address");
  a_enable_readback: assert property (
    pready && !pwrite && paddr == `IRQ_ENABLE_MASK_OFS |-> prdata == en_r)
    else $error("enable read back wrong");
  a_irq_masked: assert property (en_r == '0 |=> !irq)
    else $error("irq with all sources masked");
  a_irq_nack: assert property (s_nack_m0 |-> ##1 irq)
    else $error("irq missing after nack");
  a_irq_ahb_err: assert property (s_ahb_err |-> ##1 irq)
    else $error("irq missing after bus error");
  a_irq_multi_push: assert property (s_multi_push |-> ##1 irq)
    else $error("irq missing after multi push");
endmodule
bind sensor_subsys_irq_flags irq_flags_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  i_irq_flags_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .src(src), .irq(irq));
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the interrupt flag block.
// Assumes package, design and checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "irq_flags_params.svh"
module tb_top
  import irq_flags_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, exp, en, r;
  irq_src_t    src, s;
  int          mismatches, comparisons, seed;
  always #25 pclk = ~pclk;
  sensor_subsys_irq_flags i_sensor_subsys_irq_flags (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src), .irq(irq));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task give_verdict;
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // One APB transfer; the wait for ready is bounded
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      give_verdict;
    end
  endtask
  // Expected flag bits for one cycle of source activity
  function automatic logic [31:0] flags_of(input irq_src_t v);
    logic [31:0] f;
    f = '0;
    f[0] = v.engine_push && ($countones(v.engine_push_sel) > 1);
    f[1] = v.engine_overrun;
    f[4] = v.seq_b_overrun;
    f[5] = v.seq_a_overrun;
    f[6] = v.iic_m1_nack;
    f[7] = v.iic_m0_nack;
    f[12:8] = v.mem_sleep_access[4:0];
    f[13] = v.engine_bp;
    f[15] = v.pkt_fifo_push && v.pkt_fifo_full;
    f[16] = v.seq_a_bp;
    f[17] = v.seq_b_bp;
    f[18] = v.serial_req;
    f[21:19] = v.mem_sleep_access[7:5];
    f[22] = v.ahbm_hresp;
    return f;
  endfunction
  // Pulse sources one cycle, then read flags and look at irq
  task step(input irq_src_t v);
    @(posedge pclk);
    src <= v;
    @(posedge pclk);
    src <= '0;
    exp = exp | flags_of(v);
    apb(1'b0, `IRQ_FLAG_STATUS_OFS, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, irq}, {31'h0, |(exp & en)});
  endtask
  task clr(input logic [31:0] w);
    apb(1'b1, `IRQ_FLAG_STATUS_OFS, w);
    exp = exp & ~(w & `IRQ_FLAG_CLR_MASK);
  endtask
  task set_en(input logic [31:0] w);
    en = w;
    apb(1'b1, `IRQ_ENABLE_MASK_OFS, w);
    apb(1'b0, `IRQ_ENABLE_MASK_OFS, 32'h0000_0000);
    chk(rd, en);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 17665;
    mismatches = 0;
    comparisons = 0;
    exp = '0;
    en = '0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    src = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    step('0);
    apb(1'b0, `IRQ_ENABLE_MASK_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0000);
    // Unmapped place refuses a write and reads as zero
    apb(1'b1, 12'h104, $random(seed));
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b0, 12'h104, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // Masked nack stays quiet; corner pushes
    set_en(32'hffff_ff7f);
    s = '0;
    s.iic_m0_nack = 1'b1;
    step(s);
    s = '0;
    s.engine_push = 1'b1;
    s.engine_push_sel = 4'b0100;
    step(s);
    s = '0;
    s.pkt_fifo_push = 1'b1;
    step(s);
    s.pkt_fifo_full = 1'b1;
    step(s);
    s = '0;
    s.engine_push = 1'b1;
    s.engine_push_sel = 4'b0101;
    s.ahbm_hresp = 1'b1;
    step(s);
    clr(32'hffff_ffff);
    step('0);
    // Unmasked nack must raise the line
    set_en(32'h0000_0080);
    s = '0;
    s.iic_m0_nack = 1'b1;
    step(s);
    clr(32'hffff_ffff);
    // Sparse random events with random enables and clears
    for (int k = 0; k < 40; k++) begin
      if (k % 8 == 0) begin
        set_en($random(seed));
      end
      r = $random(seed) & $random(seed) & $random(seed);
      s = irq_src_t'(r[$bits(irq_src_t)-1:0]);
      step(s);
      clr($random(seed));
    end
    // Overruns survive a clear of every bit
    s = '0;
    s.engine_overrun = 1'b1;
    s.seq_a_overrun = 1'b1;
    s.seq_b_overrun = 1'b1;
    step(s);
    clr(32'hffff_ffff);
    step('0);
    // Event held through a clear keeps its flag
    s = '0;
    s.serial_req = 1'b1;
    src <= s;
    clr(32'h0004_0000);
    src <= '0;
    // Set wins at the colliding edge
    exp = exp | flags_of(s);
    step('0);
    // Second reset clears everything, overruns too
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    exp = '0;
    en = '0;
    step('0);
    apb(1'b0, `IRQ_ENABLE_MASK_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    set_en(32'h0000_0000);
    give_verdict;
  end
endmodule
`default_nettype wire
